/* File: rtl/scct_consts.svh */
/*
 * constants of the chopper timing and sensor-bus block: clock rate, chop and
 * sample rates, register offsets, field positions and reset values.
 * assumes nothing; included by bare name wherever a figure is needed.
 */
`ifndef SCCT_CONSTS_SVH
`define SCCT_CONSTS_SVH

// timing figures in their own units
`define SCCT_CLK_HZ        25000000   // hclk rate
`define SCCT_CHOP_TC_HZ    217        // chop rate, thermocouple family
`define SCCT_CHOP_DI_HZ    434        // chop rate, diode family
`define SCCT_MULT_TC       200        // samples per chop period, thermocouple
`define SCCT_MULT_DI       100        // samples per chop period, diode
`define SCCT_SCLK_HZ       100000     // sensor serial clock rate
// derived cycle counts
`define SCCT_SMP_DIV       (`SCCT_CLK_HZ / (`SCCT_CHOP_TC_HZ * `SCCT_MULT_TC))
`define SCCT_SCLK_HALF     (`SCCT_CLK_HZ / (2 * `SCCT_SCLK_HZ))
`define SCCT_HALF_TC       7'd100     // samples per chop half, thermocouple
`define SCCT_HALF_DI       7'd50      // samples per chop half, diode
`define SCCT_HI_GAIN       100        // gain of the amplified path

// register word indices; the byte address is four times the index
`define SCCT_A_CTRL        6'h00
`define SCCT_A_GAIN        6'h01
`define SCCT_A_THRESH      6'h02
`define SCCT_A_STATUS      6'h03
`define SCCT_A_RESULT      6'h04
`define SCCT_A_SBUS        6'h05
`define SCCT_A_AUX         6'h06

// field positions
`define SCCT_CTRL_FAM      0
`define SCCT_CTRL_RUN      1
`define SCCT_ST_LOST       1
`define SCCT_SBUS_RD       8

// reset values
`define SCCT_GAIN_RST      16'h0064
`define SCCT_THRESH_RST    16'h7000

`endif

/* File: rtl/scct_div.sv */
/*
 * free-running divider giving a one-cycle enable every DIV clocks.
 * assumes hclk and hresetn of the block; clr restarts the count.
 */
`timescale 1ns/100ps
`default_nettype none

module scct_div #(
	parameter int DIV = 576
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic clr,
	output logic      tick
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;  // cycle count in the period

	assign tick = (cnt_q == LAST) && !clr;

	// count and wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_q <= '0;
		else if (clr || tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + CW'(1);
	end

	a_div_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
		tick |=> !tick)
		else $error("divider tick repeated in back to back cycles");
endmodule : scct_div

`default_nettype wire

/* File: rtl/scct_fifo.sv */
/*
 * result fifo of flip-flops, valid and ready on both sides.
 * assumes one clock; the drain side may stall so that it fills.
 */
`timescale 1ns/100ps
`default_nettype none

module scct_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	scct_fifo_if.dst              wr,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // storage
	logic [AW-1:0]    wp_q;           // write index
	logic [AW-1:0]    rp_q;           // read index
	logic [AW:0]      cnt_q;          // words held
	wire              push = wr.valid && wr.ready;
	wire              pop  = out_valid && out_ready;

	assign wr.ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];

	// indices and fill count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage write
	always_ff @(posedge hclk) begin
		if (push)
			mem_q[wp_q] <= wr.data;
	end

	a_fifo_fill_count: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
		(push && !pop) |=> cnt_q == $past(cnt_q) + (AW+1)'(1))
		else $error("fifo count did not grow on a push");
endmodule : scct_fifo

`default_nettype wire

/* File: rtl/scct_fifo_if.sv */
/*
 * valid/ready carrier between the result producer and the result fifo.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface scct_fifo_if #(parameter int WIDTH = 32);
	logic             valid;  // word offered
	logic             ready;  // word can be taken
	logic [WIDTH-1:0] data;   // the word

	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface : scct_fifo_if

`default_nettype wire

/* File: rtl/scct_pkg.sv */
/*
 * types of the chopper timing and sensor-bus block.
 * assumes the constants header for all figures.
 */
`default_nettype none

package scct_pkg;
	// sensor family attached
	typedef enum logic {
		SCCT_FAM_TC,
		SCCT_FAM_DI
	} scct_fam_t;

	// sensor serial bus sequencer
	typedef enum logic [1:0] {
		SCCT_SB_IDLE,
		SCCT_SB_TX,
		SCCT_SB_RX
	} scct_sb_t;
endpackage : scct_pkg

`default_nettype wire

/* File: rtl/scct_top.sv */
/*
 * chopper timing, converter sample clock, gain-path choice, result fifo and
 * sensor serial bus of one measurement channel, behind an ahb-lite slave.
 * assumes a single-word ahb-lite master, a dual converter whose results
 * settle within one sample period, and all pins except the ahb-lite port asynchronous to hclk.
 */
// Design decisions made here: the AHB-Lite register port and the register offsets.
// How it works
// [R01] thermocouple sensor: chop at 217 hz
// [R02] diode sensor: chop at 434 hz
// [R03] thermocouple: sample at 200 times chop
// [R04] diode: sample at 100 times chop
// [R05] two gain paths, calibrated, one chosen
// [R06] each result is a 32-bit word
// [R07] equalizer on with diode sensor
// [R08] chopper wire becomes serial clock
// [R09] sense wire is shared serial data
// [R10] zero-select wire enables serial bus
// [R11] all rates come from one clock
// [R12] auxiliary readings only on request
// [R13] sense voltage gives presence, model, panel
// [R14] chop halves equal, integer divided
`timescale 1ns/100ps
`default_nettype none
`include "scct_consts.svh"

module scct_top #(
	parameter int SMP_DIV    = `SCCT_SMP_DIV,
	parameter int SCLK_HALF  = `SCCT_SCLK_HALF,
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             chop_drv,
	output logic             adc_start,
	input  wire logic [15:0] adc_lo,
	input  wire logic [15:0] adc_hi,
	output logic             eq_on,
	output logic             sbus_en,
	output logic             sense_o,
	output logic             sense_oe,
	input  wire logic        sense_i,
	input  wire logic [7:0]  sense_level,
	input  wire logic [15:0] aux_in
);
	// synchronisers for every pin input outside the ahb-lite port
	logic [15:0] lo_s1_q, lo_q, hi_s1_q, hi_q, aux_s1_q, aux_sy_q;
	logic [7:0]  lvl_s1_q, lvl_q;
	logic        sda_s1_q, sda_q;

	// two flip-flops on each asynchronous input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{lo_s1_q, lo_q, hi_s1_q, hi_q} <= '0;
			{aux_s1_q, aux_sy_q, lvl_s1_q, lvl_q} <= '0;
			{sda_s1_q, sda_q} <= '0;
		end else begin
			{lo_s1_q, hi_s1_q, aux_s1_q} <= {adc_lo, adc_hi, aux_in};
			{lo_q, hi_q, aux_sy_q}       <= {lo_s1_q, hi_s1_q, aux_s1_q};
			{lvl_s1_q, sda_s1_q}         <= {sense_level, sense_i};
			{lvl_q, sda_q}               <= {lvl_s1_q, sda_s1_q};
		end
	end

	// software registers
	logic        fam_q, run_q;          // family select, chop enable
	logic [15:0] gain_q, thresh_q;      // lo-path gain, hi-path clip level
	logic        lost_q;                // a result found the fifo full
	logic [15:0] aux_q;                 // requested auxiliary reading
	logic        aux_rdy_q;             // aux reading waiting
	logic [7:0]  sb_rx_q;               // last byte read from sensor
	logic        hi_used_q;             // last sample took hi path

	// ahb address phase capture
	logic       wr_pend_q;             // write data phase due
	logic [5:0] wr_idx_q;              // its word index
	wire        acc_ok = hsel && htrans[1] && hready;
	wire        rd_acc = acc_ok && !hwrite;
	wire        wr_acc = acc_ok && hwrite && (hsize == 3'b010);
	wire [5:0]  a_idx  = haddr[7:2];
	wire        wr_now = wr_pend_q;
	wire        wr_ctl = wr_now && (wr_idx_q == `SCCT_A_CTRL);
	wire        wr_gn  = wr_now && (wr_idx_q == `SCCT_A_GAIN);
	wire        wr_th  = wr_now && (wr_idx_q == `SCCT_A_THRESH);
	wire        wr_st  = wr_now && (wr_idx_q == `SCCT_A_STATUS);
	wire        wr_sb  = wr_now && (wr_idx_q == `SCCT_A_SBUS);
	wire        aux_req = wr_now && (wr_idx_q == `SCCT_A_AUX);

	assign hreadyout = 1'b1;  // zero wait states
	assign hresp     = 1'b0;  // always okay
	assign eq_on     = fam_q; // [R07]

	// sample clock and chopper
	logic       smp_en;                // one pulse per conversion
	logic       chop_q;                // chop phase, 1 = upper level
	logic [6:0] half_cnt_q;            // samples in this half
	wire  [6:0] half_n = fam_q ? `SCCT_HALF_DI : `SCCT_HALF_TC; // [R03] [R04]
	logic       sb_busy;               // serial transaction in flight
	wire        chop_run = run_q && !sb_busy;
	wire        half_end = smp_en && chop_run && (half_cnt_q == half_n - 7'd1);

	scct_div #(.DIV(SMP_DIV)) u_smp_div ( // [R11]
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (!chop_run),
		.tick    (smp_en)
	);

	// chop phase toggles after an equal count of samples each half
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chop_q     <= 1'b1;
			half_cnt_q <= '0;
			adc_start  <= 1'b0;
		end else begin
			adc_start <= smp_en;                  // [R03] [R04]
			if (!chop_run) begin
				chop_q     <= 1'b1;
				half_cnt_q <= '0;
			end else if (half_end) begin
				chop_q     <= !chop_q;               // [R01] [R02] [R14]
				half_cnt_q <= '0;
			end else if (smp_en)
				half_cnt_q <= half_cnt_q + 7'd1;
		end
	end

	// gain path choice and demodulation
	wire signed [15:0] hi_s   = signed'(hi_q);
	wire signed [15:0] lo_s   = signed'(lo_q);
	wire        [15:0] hi_mag = hi_s[15] ? 16'(-hi_s) : 16'(hi_s);
	wire               use_hi = hi_mag < thresh_q;  // [R05]
	wire signed [31:0] lo_cal = lo_s * signed'({1'b0, gain_q[14:0]});
	wire signed [31:0] smp_v  = use_hi ? 32'(hi_s) : lo_cal; // [R05]
	logic signed [31:0] acc_q;         // running demodulated sum
	logic        [31:0] res_q;         // finished period result
	logic               res_v_q;       // result waiting for fifo
	wire                per_end = half_end && !chop_q;
	wire signed [31:0]  acc_d = chop_q ? acc_q + smp_v : acc_q - smp_v;

	scct_fifo_if #(.WIDTH(32)) res_if ();
	assign res_if.valid = res_v_q;
	assign res_if.data  = res_q;

	// accumulate per chop period, hand over at period end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q     <= '0;
			res_q     <= '0;
			res_v_q   <= 1'b0;
			hi_used_q <= 1'b0;
		end else begin
			if (res_v_q && res_if.ready)
				res_v_q <= 1'b0;           // fifo took it
			if (!chop_run)
				acc_q <= '0;
			else if (smp_en) begin
				hi_used_q <= use_hi;
				acc_q     <= per_end ? '0 : acc_d;
				if (per_end) begin
					res_q   <= 32'(acc_d);   // [R06]
					res_v_q <= 1'b1;
				end
			end
		end
	end

	logic        fifo_v;
	logic [31:0] fifo_d;
	wire         res_rd = rd_acc && (a_idx == `SCCT_A_RESULT);

	scct_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.wr        (res_if.dst),
		.out_valid (fifo_v),
		.out_ready (res_rd),
		.out_data  (fifo_d)
	);

	// sensor serial bus on chop and sense wires
	scct_pkg::scct_sb_t sb_st_q;
	logic       sclk_q;                // serial clock level
	logic [7:0] sb_sh_q;               // shift register
	logic [2:0] sb_bit_q;              // bit index
	logic       sb_rd_q;               // read after the command byte
	logic       sclk_tick;
	assign sb_busy = (sb_st_q != scct_pkg::SCCT_SB_IDLE);

	scct_div #(.DIV(SCLK_HALF)) u_sclk_div ( // [R11]
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (!sb_busy),
		.tick    (sclk_tick)
	);

	// shift out on falling edge, sample in on rising edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sb_st_q  <= scct_pkg::SCCT_SB_IDLE;
			sclk_q   <= 1'b0;
			sb_sh_q  <= '0;
			sb_bit_q <= '0;
			sb_rd_q  <= 1'b0;
			sb_rx_q  <= '0;
		end else begin
			unique case (sb_st_q)
				scct_pkg::SCCT_SB_IDLE: begin
					sclk_q <= 1'b0;
					if (wr_sb) begin
						sb_sh_q  <= hwdata[7:0];
						sb_rd_q  <= hwdata[`SCCT_SBUS_RD];
						sb_bit_q <= '0;
						sb_st_q  <= scct_pkg::SCCT_SB_TX;
					end
				end
				scct_pkg::SCCT_SB_TX: if (sclk_tick) begin
					sclk_q <= !sclk_q;
					if (sclk_q) begin
						sb_sh_q  <= {sb_sh_q[6:0], 1'b0};
						sb_bit_q <= sb_bit_q + 3'd1;
						if (sb_bit_q == 3'd7)
							sb_st_q <= sb_rd_q ? scct_pkg::SCCT_SB_RX
							                   : scct_pkg::SCCT_SB_IDLE;
					end
				end
				scct_pkg::SCCT_SB_RX: if (sclk_tick) begin
					sclk_q <= !sclk_q;
					if (!sclk_q)
						sb_sh_q <= {sb_sh_q[6:0], sda_q}; // [R09]
					else begin
						sb_bit_q <= sb_bit_q + 3'd1;
						if (sb_bit_q == 3'd7) begin
							sb_rx_q <= sb_sh_q;
							sb_st_q <= scct_pkg::SCCT_SB_IDLE;
						end
					end
				end
			endcase
		end
	end

	// pin drivers, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chop_drv <= 1'b1;
			sbus_en  <= 1'b0;
			sense_o  <= 1'b0;
			sense_oe <= 1'b0;
		end else begin
			chop_drv <= sb_busy ? sclk_q : chop_q;           // [R08]
			sbus_en  <= sb_busy;                             // [R10]
			sense_oe <= (sb_st_q == scct_pkg::SCCT_SB_TX);   // [R09]
			sense_o  <= sb_sh_q[7];
		end
	end

	// control registers and write side effects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
			fam_q     <= 1'b0;
			run_q     <= 1'b0;
			gain_q    <= `SCCT_GAIN_RST;
			thresh_q  <= `SCCT_THRESH_RST;
			lost_q    <= 1'b0;
			aux_q     <= '0;
			aux_rdy_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_acc;
			wr_idx_q  <= a_idx;
			if (wr_ctl) begin
				fam_q <= hwdata[`SCCT_CTRL_FAM];
				run_q <= hwdata[`SCCT_CTRL_RUN];
			end
			if (wr_gn)
				gain_q <= hwdata[15:0];
			if (wr_th)
				thresh_q <= hwdata[15:0];
			// set wins over clear
			if (res_v_q && !res_if.ready && smp_en && per_end)
				lost_q <= 1'b1;
			else if (wr_st && hwdata[`SCCT_ST_LOST])
				lost_q <= 1'b0;
			if (aux_req) begin
				aux_q     <= aux_sy_q;                        // [R12]
				aux_rdy_q <= 1'b1;
			end else if (rd_acc && a_idx == `SCCT_A_AUX)
				aux_rdy_q <= 1'b0;
		end
	end

	// sensor presence, model and panel from sense voltage
	wire       present = (lvl_q != 8'hff);                    // [R13]
	wire       rear    = lvl_q[7];
	wire [6:0] model   = lvl_q[6:0];
	wire [31:0] st_word = {18'h0, hi_used_q, model, rear, present,
	                       aux_rdy_q, sb_busy, lost_q, fifo_v};
	wire [31:0] rd_mux =
		(a_idx == `SCCT_A_CTRL)   ? {30'h0, run_q, fam_q} :
		(a_idx == `SCCT_A_GAIN)   ? {16'h0, gain_q} :
		(a_idx == `SCCT_A_THRESH) ? {16'h0, thresh_q} :
		(a_idx == `SCCT_A_STATUS) ? st_word :
		(a_idx == `SCCT_A_RESULT) ? (fifo_v ? fifo_d : 32'h0) :
		(a_idx == `SCCT_A_SBUS)   ? {24'h0, sb_rx_q} :
		(a_idx == `SCCT_A_AUX)    ? {16'h0, aux_q} : 32'h0;

	// read data launched in address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= '0;
		else if (rd_acc)
			hrdata <= rd_mux;
	end

	a_chop_toggle_end: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
		half_end |=> chop_q != $past(chop_q))
		else $error("chop did not toggle at half end");
	a_chop_hold_mid: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
		(chop_run && !half_end && $past(chop_run)) |=> $stable(chop_q))
		else $error("chop toggled inside a half");
	a_half_count_tc: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
		(half_end && !fam_q) |-> half_cnt_q == 7'd99)
		else $error("thermocouple half not 100 samples");
	a_half_count_di: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
		(half_end && fam_q) |-> half_cnt_q == 7'd49)
		else $error("diode half not 50 samples");
	a_start_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R03] [R04]
		smp_en |=> adc_start ##1 !adc_start)
		else $error("converter start not one cycle after sample tick");
	a_sclk_on_chop: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
		sb_busy |=> chop_drv == $past(sclk_q))
		else $error("chop wire not carrying serial clock");
	a_bus_enable: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
		$rose(sb_busy) |=> sbus_en throughout (sb_busy [*1]))
		else $error("serial bus enable missing during transaction");
	a_data_turn: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
		(sb_st_q == scct_pkg::SCCT_SB_RX) |=> !sense_oe)
		else $error("sense wire driven during sensor turn");
	a_eq_diode: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
		(wr_ctl && hwdata[`SCCT_CTRL_FAM]) |=> eq_on)
		else $error("equalizer off with diode sensor");
	a_aux_request: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
		$changed(aux_q) |-> $past(aux_req))
		else $error("aux reading taken without a request");
	a_gain_choice: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
		(smp_en && chop_run) |=> hi_used_q == $past(use_hi))
		else $error("gain path choice not recorded");
	a_result_push: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
		(smp_en && per_end) |=> res_v_q && res_q == $past(acc_d))
		else $error("period result not offered");
	a_sense_absent: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
		(lvl_q == 8'hff) |-> !st_word[4])
		else $error("sensor shown present at open-wire level");
endmodule : scct_top

`default_nettype wire

/* File: verif/scct_sensor_model.sv */
/*
 * far-side model: sensor on the chop, sense and zero-select wires, and the
 * dual converter answering each start pulse.
 * assumes the block's pins, hclk, and byte and sample values from the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module scct_sensor_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        chop_drv,
	input  wire logic        sbus_en,
	input  wire logic        sense_o,
	input  wire logic        sense_oe,
	output logic             sense_i,
	input  wire logic        adc_start,
	input  wire logic [15:0] hi_set,
	input  wire logic [15:0] lo_set,
	output logic [15:0]      adc_lo,
	output logic [15:0]      adc_hi,
	input  wire logic [7:0]  tx_byte,
	output logic [7:0]       rx_byte
);
	logic [4:0] cnt_q;  // serial clock rises in this frame
	logic       drv_q;  // sensor drives the wire
	logic       bit_q;  // bit the sensor drives
	logic       last_q = 1'b0; // last wire level, known from the start

	// wire level; a released wire shows the inverse of its last level
	assign sense_i = sense_oe ? sense_o : (drv_q ? bit_q : ~last_q);

	// remember the wire level
	always @(posedge hclk) begin
		last_q <= sense_i;
	end

	// count clock rises, take device bits msb first
	always @(posedge chop_drv or negedge sbus_en) begin
		if (!sbus_en) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
			if (sense_oe) begin
				rx_byte <= {rx_byte[6:0], sense_o};
			end
		end
	end

	// answer after a fall, only in the sensor's own turn
	always @(negedge chop_drv or negedge sbus_en) begin
		if (!sbus_en) begin
			drv_q <= 1'b0;
		end else begin
			drv_q <= (cnt_q >= 5'd8) && (cnt_q < 5'd16);
			bit_q <= tx_byte[3'(5'd15 - cnt_q)];
		end
	end

	// converter: fresh pair after each start pulse
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_hi <= 16'h0000;
			adc_lo <= 16'h0000;
		end else if (adc_start) begin
			adc_hi <= hi_set;
			adc_lo <= lo_set;
		end
	end
endmodule : scct_sensor_model

`default_nettype wire

/* File: verif/sensor_chop_timing_control_tb.sv */
/*
 * self-checking bench: ahb-lite tasks, chop and sample timing, result fifo,
 * sensor identity, auxiliary reading and one serial frame.
 * assumes the block with short divider counts and the sensor model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "scct_consts.svh"

module sensor_chop_timing_control_tb;
	localparam int SMP = 8; // shortened sample divider
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010;
	logic        hreadyout, hresp, chop_drv, adc_start, eq_on, sbus_en;
	logic        sense_o, sense_oe, sense_i;
	logic [15:0] adc_lo, adc_hi, aux_in = 16'h0000;
	logic [7:0]  sense_level = 8'hff, tx_byte = 8'h00, rx_byte;
	int          n_mismatch = 0, checked = 0, c, p, c2, n;

	always #20 hclk = ~hclk;

	scct_top #(.SMP_DIV(SMP), .SCLK_HALF(4)) scct_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .chop_drv(chop_drv), .adc_start(adc_start),
		.adc_lo(adc_lo), .adc_hi(adc_hi), .eq_on(eq_on), .sbus_en(sbus_en),
		.sense_o(sense_o), .sense_oe(sense_oe), .sense_i(sense_i),
		.sense_level(sense_level), .aux_in(aux_in));

	scct_sensor_model scct_sensor_model_inst (
		.hclk(hclk), .hresetn(hresetn), .chop_drv(chop_drv),
		.sbus_en(sbus_en), .sense_o(sense_o), .sense_oe(sense_oe),
		.sense_i(sense_i), .adc_start(adc_start), .hi_set(16'h0100),
		.lo_set(16'h0002), .adc_lo(adc_lo), .adc_hi(adc_hi),
		.tx_byte(tx_byte), .rx_byte(rx_byte));

	// verdict and end of run
	task automatic end_of_test;
		$display("mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// wait for hready high at an edge, bounded
	task automatic wait_rdy;
		for (n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (n == 20) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wait_rdy

	// one single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask : rd

	// length of one chop half in clocks and start pulses within it
	task automatic half(output int cyc, output int pulses);
		logic lvl;
		lvl = chop_drv;
		cyc = 0;
		pulses = 0;
		while (chop_drv === lvl && cyc < 5000) begin
			@(posedge hclk);
			cyc++;
			if (adc_start === 1'b1) pulses++;
		end
	endtask : half

	// main sequence
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'h04, st);
		chk(st, 32'h0000_0064);
		rd(32'h08, st);
		chk(st, 32'h0000_7000);
		rd(32'h3c, st);
		chk(st, 32'h0);
		chk(32'(hresp), 32'h0);
		// sensor present, rear, model five; then absent; the level passes a synchroniser
		sense_level <= 8'h85;
		repeat (2) @(posedge hclk);
		rd(32'h0c, st);
		chk(32'(st[12:4]), 32'h17);
		sense_level <= 8'hff;
		repeat (2) @(posedge hclk);
		rd(32'h0c, st);
		chk(32'(st[4]), 32'h0);
		// auxiliary reading only on request
		aux_in <= 16'h1234;
		rd(32'h0c, st);
		chk(32'(st[3]), 32'h0);
		wr(32'h18, 32'h0);
		aux_in <= 16'h4321;
		rd(32'h0c, st);
		chk(32'(st[3]), 32'h1);
		rd(32'h18, st);
		chk(32'(st[15:0]), 32'h1234);
		rd(32'h0c, st);
		chk(32'(st[3]), 32'h0);
		// thermocouple family, high gain path
		wr(32'h00, 32'h2);
		@(posedge hclk); // control write lands at the edge the task returns on
		chk(32'(eq_on), 32'h0);
		half(c, p);
		half(c, p);
		chk(c, 100 * SMP);
		chk(p, 100);
		half(c2, p);
		chk(c2, c);
		repeat (8000) @(posedge hclk);
		wr(32'h00, 32'h0);
		rd(32'h0c, st);
		chk(32'({st[13], st[1:0]}), 32'h7);
		// first conversion of the run still sees the converter's idle zero,
		// so the first period nets one sample short; later periods cancel
		for (int i = 0; i < 4; i++) begin
			rd(32'h10, st);
			chk(st, (i == 0) ? 32'hffff_ff00 : 32'h0);
		end
		// the word held back while full has moved into the fifo
		rd(32'h0c, st);
		chk(32'(st[0]), 32'h1);
		rd(32'h10, st);
		chk(st, 32'h0);
		rd(32'h0c, st);
		chk(32'(st[0]), 32'h0);
		wr(32'h0c, 32'h2);
		rd(32'h0c, st);
		chk(32'(st[1]), 32'h0);
		// diode family, clipped high path so the low path is used
		wr(32'h08, 32'h80);
		wr(32'h04, 32'h5);
		wr(32'h00, 32'h3);
		@(posedge hclk); // control write lands at the edge the task returns on
		chk(32'(eq_on), 32'h1);
		half(c, p);
		half(c, p);
		chk(c, 50 * SMP);
		chk(p, 50);
		half(c2, p);
		chk(c2, c);
		half(c2, p);
		rd(32'h0c, st);
		chk(32'(st[13]), 32'h0);
		wr(32'h00, 32'h0);
		// one serial frame: byte out, byte back
		tx_byte <= 8'h3c;
		wr(32'h14, 32'h1a5);
		for (n = 0; n < 50 && sbus_en !== 1'b1; n++) @(posedge hclk);
		chk(32'(sbus_en), 32'h1);
		for (n = 0; n < 400 && sbus_en !== 1'b0; n++) @(posedge hclk);
		chk(32'(sbus_en), 32'h0);
		chk(32'(rx_byte), 32'ha5);
		rd(32'h0c, st);
		chk(32'(st[2]), 32'h0);
		rd(32'h14, st);
		chk(32'(st[7:0]), 32'h3c);
		end_of_test();
	end
endmodule : sensor_chop_timing_control_tb

`default_nettype wire
